/* hw/ats_params.svh */
// Constants of the acquisition trigger sequencer: offsets, fields, resets, timing.
// Assumes a 40 MHz core clock; included by the package and the top module.
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH
`define ATS_CLK_HZ          40000000
`define ATS_TICK_US         1
`define ATS_TICK_CYC        ((`ATS_CLK_HZ / 1000000) * `ATS_TICK_US)
`define ATS_CLK_PER_NS      25
`define ATS_EVT_MIN_NS      20
`define ATS_EVT_MAX_NS      30
`define ATS_EVT_CYC         ((`ATS_EVT_MIN_NS + `ATS_CLK_PER_NS - 1) / `ATS_CLK_PER_NS)
`define ATS_B1_LIMIT_US     218
`define ATS_B1_BASE_US      219
`define ATS_B1_SHORT_US     1
`define ATS_FINAL_BUSY_US   218
`define ATS_ACQ_MAX_US      335500
`define ATS_INT_MAX_US      6000000
`define ATS_OFF_CTRL        8'h00
`define ATS_OFF_STATUS      8'h04
`define ATS_OFF_ACQ         8'h08
`define ATS_OFF_INTEG       8'h0C
`define ATS_OFF_SSDLY       8'h10
`define ATS_OFF_SSW         8'h14
`define ATS_OFF_CSPER       8'h18
`define ATS_CTRL_MODE_LSB   0
`define ATS_CTRL_SWTRIG_BIT 4
`define ATS_STAT_BUSY_BIT   0
`define ATS_STAT_INTEG_BIT  1
`define ATS_MODE_SW         2'h0
`define ATS_MODE_EDGE       2'h1
`define ATS_MODE_LEVEL      2'h2
`define ATS_INTEG_RST       32'h000003E8
`define ATS_ZERO_RST        32'h00000000
`endif

/* hw/ats_pkg.sv */
// Types of the acquisition trigger sequencer.
// Assumes nothing beyond the params header.
`include "ats_params.svh"
package ats_pkg;
   typedef enum logic [1:0] {S_IDLE, S_BUSY1, S_INTEG, S_BUSY2} ats_state_e;
   typedef logic [1:0] ats_mode_t;
endpackage

/* hw/ats_top.sv */
// Acquisition trigger sequencer with APB registers and strobe outputs.
// Assumes ext_trig synchronous to core_clk and an APB master on core_clk.
// How it works
// - Edge mode: rising external trigger edge starts an acquisition cycle.
// - Trigger event registered 20 to 30 ns after the rising edge.
// - Cycle: initial busy plus delay, integration, final busy, then end.
// - Acquisition delay programmable 0 to 335500 us in 1 us steps.
// - Integration time programmable in 1 us steps, up to 6 s.
// - Initial busy 1 us if integration >= 218 us, else 219 minus it.
// - Single strobe delay counts from the trigger event, not integration.
// - Single strobe high time set by programmable width in 1 us steps.
// - Single strobe forced low when integration ends.
// - Pulse train starts when integration starts.
// - Only complete pulse train periods fit within integration.
// - Pulse train only when its period is shorter than integration.
// - Pulse train 50% duty; off and low if next period cannot finish.
// - One single strobe per cycle, rising when its delay expires.
// - Modes software, edge, level (level starts on the rising edge, as edge does); software is the reset default.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "ats_params.svh"
module ats_top
   import ats_pkg::*;
#(
   parameter int TICK_CYC      = `ATS_TICK_CYC,
   parameter int FINAL_BUSY_US = `ATS_FINAL_BUSY_US,
   parameter int ACQ_W         = 19,
   parameter int INT_W         = 23,
   parameter int EL_W          = 24
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_trig,
   output logic             single_strobe,
   output logic             pulse_train,
   output logic             acq_busy,
   output logic             integrating
);
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

   ats_state_e       st_q;
   ats_mode_t        mode_q;
   logic [ACQ_W-1:0] acq_q;
   logic [INT_W-1:0] integ_q;
   logic [INT_W-1:0] int_snap_q;
   logic [EL_W-1:0]  ssdly_q;
   logic [EL_W-1:0]  ssw_q;
   logic [INT_W-1:0] csper_q;
   logic [INT_W-1:0] per_snap_q;
   logic             sw_req_q;
   logic             trig_prev_q;
   logic             evt_q;
   logic [7:0]       presc_q;
   logic [EL_W-1:0]  cnt_q;
   logic [EL_W-1:0]  el_q;
   logic [INT_W-1:0] cs_pos_q;
   logic             cs_on_q;
   logic [INT_W-1:0] b1_q;
   logic [31:0]      prdata_q;
   logic             pready_q;
   logic             pslverr_q;
   logic             ss_q;
   logic             cs_q;
   logic             busy_q;
   logic             integ_out_q;

   logic             edge_w;
   logic             trig_ok;
   logic             tick;
   logic [INT_W-1:0] b1_d;
   logic [EL_W-1:0]  cnt_nx;
   logic [EL_W-1:0]  b1_end;
   logic             wr_en;
   logic             mapped;
   logic [31:0]      rd_d;
   logic [EL_W-1:0]  rem_after;
   logic [31:0]      pos_cyc;
   logic [31:0]      half_cyc;

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign single_strobe = ss_q;
   assign pulse_train   = cs_q;
   assign acq_busy      = busy_q;
   assign integrating   = integ_out_q;

   // Edge seen in the clock it arrives; event lands one clock (25 ns) after the edge
   assign edge_w  = ext_trig && !trig_prev_q;
   assign trig_ok = (st_q == S_IDLE) && !evt_q &&
                    (((mode_q != `ATS_MODE_SW) && edge_w) ||
                     ((mode_q == `ATS_MODE_SW) && sw_req_q));
   assign tick    = ce && (presc_q == TICK_LAST);
   assign cnt_nx  = cnt_q + EL_W'(1);

   // Short-busy variant: busy shrinks as integration nears the limit
   always_comb begin
      if (integ_q >= INT_W'(`ATS_B1_LIMIT_US)) begin
         b1_d = INT_W'(`ATS_B1_SHORT_US);
      end else begin
         b1_d = INT_W'(`ATS_B1_BASE_US) - integ_q;
      end
   end
   assign b1_end = EL_W'(b1_q) + EL_W'(acq_q);

   assign rem_after = EL_W'(int_snap_q) - cnt_nx;
   assign pos_cyc   = 32'(cs_pos_q) * 32'(TICK_CYC) + 32'(presc_q);
   assign half_cyc  = (32'(per_snap_q) * 32'(TICK_CYC)) >> 1;

   // APB: one wait state, answer in the second access cycle
   assign wr_en  = ce && psel && penable && pready_q && pwrite;
   assign mapped = (paddr == `ATS_OFF_CTRL) || (paddr == `ATS_OFF_STATUS) ||
                   (paddr == `ATS_OFF_ACQ) || (paddr == `ATS_OFF_INTEG) ||
                   (paddr == `ATS_OFF_SSDLY) || (paddr == `ATS_OFF_SSW) ||
                   (paddr == `ATS_OFF_CSPER);

   always_comb begin
      case (paddr)
         `ATS_OFF_CTRL:   rd_d = {30'h00000000, mode_q};
         `ATS_OFF_STATUS: rd_d = {30'h00000000, integ_out_q, busy_q};
         `ATS_OFF_ACQ:    rd_d = 32'(acq_q);
         `ATS_OFF_INTEG:  rd_d = 32'(integ_q);
         `ATS_OFF_SSDLY:  rd_d = 32'(ssdly_q);
         `ATS_OFF_SSW:    rd_d = 32'(ssw_q);
         `ATS_OFF_CSPER:  rd_d = 32'(csper_q);
         default:         rd_d = 32'h00000000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else if (ce) begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
         if (psel && !penable && !pwrite) begin
            prdata_q <= rd_d;
         end
      end
   end

   // Timing settings; integration and period changes take effect at the next trigger event, delay and strobe changes at once
   always_ff @(posedge core_clk) begin
      if (rst) begin
         mode_q  <= `ATS_MODE_SW;
         acq_q   <= ACQ_W'(`ATS_ZERO_RST);
         integ_q <= INT_W'(`ATS_INTEG_RST);
         ssdly_q <= EL_W'(`ATS_ZERO_RST);
         ssw_q   <= EL_W'(`ATS_ZERO_RST);
         csper_q <= INT_W'(`ATS_ZERO_RST);
      end else if (wr_en) begin
         case (paddr)
            `ATS_OFF_CTRL:  mode_q  <= pwdata[`ATS_CTRL_MODE_LSB +: 2];
            `ATS_OFF_ACQ:   acq_q   <= pwdata[ACQ_W-1:0];
            `ATS_OFF_INTEG: integ_q <= pwdata[INT_W-1:0];
            `ATS_OFF_SSDLY: ssdly_q <= pwdata[EL_W-1:0];
            `ATS_OFF_SSW:   ssw_q   <= pwdata[EL_W-1:0];
            `ATS_OFF_CSPER: csper_q <= pwdata[INT_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Software trigger request lives one cycle; dropped if a cycle runs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sw_req_q <= 1'b0;
      end else if (ce) begin
         sw_req_q <= wr_en && (paddr == `ATS_OFF_CTRL) &&
                     pwdata[`ATS_CTRL_SWTRIG_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         trig_prev_q <= 1'b0;
         evt_q       <= 1'b0;
      end else if (ce) begin
         trig_prev_q <= ext_trig;
         evt_q       <= trig_ok;
      end
   end

   // Sequencer; prescaler restarts at the event so no tick jitter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q       <= S_IDLE;
         presc_q    <= 8'h00;
         cnt_q      <= EL_W'(`ATS_ZERO_RST);
         el_q       <= EL_W'(`ATS_ZERO_RST);
         b1_q       <= INT_W'(`ATS_ZERO_RST);
         int_snap_q <= INT_W'(`ATS_ZERO_RST);
         per_snap_q <= INT_W'(`ATS_ZERO_RST);
      end else if (ce) begin
         if (st_q == S_IDLE) begin
            presc_q <= 8'h00;
         end else if (tick) begin
            presc_q <= 8'h00;
         end else begin
            presc_q <= presc_q + 8'h01;
         end
         if (tick) begin
            el_q <= el_q + EL_W'(1);
         end
         case (st_q)
            S_IDLE: begin
               if (evt_q) begin
                  st_q       <= S_BUSY1;
                  cnt_q      <= EL_W'(`ATS_ZERO_RST);
                  el_q       <= EL_W'(`ATS_ZERO_RST);
                  b1_q       <= b1_d;
                  int_snap_q <= integ_q;
                  per_snap_q <= csper_q;
               end
            end
            S_BUSY1: begin
               if (tick) begin
                  if (cnt_nx >= b1_end) begin
                     st_q  <= S_INTEG;
                     cnt_q <= EL_W'(`ATS_ZERO_RST);
                  end else begin
                     cnt_q <= cnt_nx;
                  end
               end
            end
            S_INTEG: begin
               if (tick) begin
                  if (cnt_nx >= EL_W'(int_snap_q)) begin
                     st_q  <= S_BUSY2;
                     cnt_q <= EL_W'(`ATS_ZERO_RST);
                  end else begin
                     cnt_q <= cnt_nx;
                  end
               end
            end
            S_BUSY2: begin
               if (tick) begin
                  if (cnt_nx >= EL_W'(FINAL_BUSY_US)) begin
                     st_q  <= S_IDLE;
                     cnt_q <= EL_W'(`ATS_ZERO_RST);
                  end else begin
                     cnt_q <= cnt_nx;
                  end
               end
            end
            default: begin
               st_q <= S_IDLE;
            end
         endcase
      end
   end

   // Pulse train: each period starts only if it fits the time left
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_pos_q <= INT_W'(`ATS_ZERO_RST);
         cs_on_q  <= 1'b0;
      end else if (ce) begin
         if (st_q == S_BUSY1 && tick && cnt_nx >= b1_end) begin
            cs_pos_q <= INT_W'(`ATS_ZERO_RST);
            cs_on_q  <= (per_snap_q != '0) && (per_snap_q < int_snap_q);
         end else if (st_q != S_INTEG) begin
            cs_on_q <= 1'b0;
         end else if (tick) begin
            if (cs_pos_q + INT_W'(1) >= per_snap_q) begin
               cs_pos_q <= INT_W'(`ATS_ZERO_RST);
               cs_on_q  <= cs_on_q && (rem_after >= EL_W'(per_snap_q));
            end else begin
               cs_pos_q <= cs_pos_q + INT_W'(1);
            end
         end
      end
   end

   // Outputs registered; they trail the state by one clock, except busy, which rises one clock after the event
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ss_q        <= 1'b0;
         cs_q        <= 1'b0;
         busy_q      <= 1'b0;
         integ_out_q <= 1'b0;
      end else if (ce) begin
         ss_q <= ((st_q == S_BUSY1) || (st_q == S_INTEG)) &&
                 (el_q >= ssdly_q) && ((el_q - ssdly_q) < ssw_q);
         cs_q <= (st_q == S_INTEG) && cs_on_q && (pos_cyc < half_cyc);
         busy_q      <= (st_q != S_IDLE) || evt_q;
         integ_out_q <= (st_q == S_INTEG);
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence s_armed_edge;
      ce && trig_ok && (mode_q == `ATS_MODE_EDGE);
   endsequence
   sequence s_tick_wrap;
      tick ##1 (presc_q == 8'h00);
   endsequence

   AST_EDGE_EVENT: assert property (s_armed_edge |=> evt_q)
      else $error("edge did not raise trigger event");
   AST_EVT_START: assert property (ce && evt_q |=> st_q == S_BUSY1)
      else $error("event did not start busy phase");
   AST_NO_RETRIG: assert property (evt_q |-> $past(st_q == S_IDLE))
      else $error("trigger accepted during a cycle");
   AST_B1_LEN: assert property (ce && evt_q |=> b1_q == $past(b1_d))
      else $error("initial busy length wrong");
   AST_TICK: assert property (tick |-> s_tick_wrap)
      else $error("prescaler did not wrap");
   AST_SS_OFF: assert property (ss_q |-> $past(st_q == S_BUSY1 || st_q == S_INTEG))
      else $error("single strobe outside window");
   AST_SS_WIDTH: assert property ($rose(ss_q) |-> ssw_q != '0)
      else $error("single strobe with zero width");
   AST_CS_INTEG: assert property (cs_q |-> $past(st_q == S_INTEG))
      else $error("pulse train outside integration");
   AST_CS_SHORT: assert property (cs_q |-> per_snap_q < int_snap_q)
      else $error("pulse train with period too long");
   AST_MODE_RST: assert property ($fell(rst) |-> mode_q == `ATS_MODE_SW)
      else $error("default mode not software");
endmodule

/* dv/ats_trig_src.sv */
// External trigger source model driving the sequencer trigger input.
// Assumes fire is a one-cycle request and hold is at least 1.
`timescale 1ns/10ps
module ats_trig_src (
   input  wire logic       core_clk,
   input  wire logic       fire,
   input  wire logic [2:0] hold,
   output logic            ext_trig
);
   logic       trig_q = 1'b0;
   logic [2:0] left_q = 3'h0;
   assign ext_trig = trig_q;
   // High for hold+1 cycles, always well past the minimum high time
   always @(posedge core_clk) begin
      if (fire) begin
         trig_q <= 1'b1;
         left_q <= hold;
      end else if (left_q != 3'h0) begin
         left_q <= left_q - 3'h1;
      end else begin
         trig_q <= 1'b0;
      end
   end
endmodule

/* dv/tb_ats_top.sv */
// Self-checking bench for the acquisition trigger sequencer.
// Assumes the design answers APB with one wait state and a shortened tick.
`timescale 1ns/10ps
`include "ats_params.svh"
module tb_ats_top;
   localparam int TC = 4;
   localparam int FB = `ATS_FINAL_BUSY_US;
   logic        core_clk, rst, ce, psel, penable, pwrite, fire;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0]  hold;
   logic        pready, pslverr, ext_trig, single_strobe, pulse_train, acq_busy, integrating;
   logic [33:0] ea;
   logic [33:0] q_apb[$];
   int          q_busy[$], q_int[$], q_gap[$], q_ofs[$], q_ss[$], q_ph[$], q_cnt[$];
   int          miscompares = 0, comparisons = 0, tcnt = 0, bw, iw, sw, pw, np;
   int          integ, acq, ssd, ssw, per, n;

   ats_top #(.TICK_CYC(TC), .FINAL_BUSY_US(FB)) ats_top_i (
      .core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_trig(ext_trig), .single_strobe(single_strobe),
      .pulse_train(pulse_train), .acq_busy(acq_busy), .integrating(integrating));
   ats_trig_src ats_trig_src_i (.core_clk(core_clk), .fire(fire), .hold(hold),
      .ext_trig(ext_trig));

   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (e !== g) begin
         miscompares++;
         $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   // Range pops allow one clock of output lag against the event
   task automatic pop(input string nm, ref int q[$], input int g, input bit rng);
      int e;
      if (q.size() == 0) begin
         miscompares++;
         $display("[FAIL] %s expected none seen %0d", nm, g);
      end else begin
         e = q.pop_front();
         if (rng && g == e + 1) g = e;
         check(nm, 32'(e), 32'(g));
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] e);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      q_apb.push_back(e);
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic prog;
      int b1, se;
      b1 = (integ >= `ATS_B1_LIMIT_US) ? `ATS_B1_SHORT_US : `ATS_B1_BASE_US - integ;
      se = (ssd + ssw < b1 + acq + integ) ? ssd + ssw : b1 + acq + integ;
      apb(1'b1, `ATS_OFF_ACQ, 32'(acq), 34'h0);
      apb(1'b1, `ATS_OFF_INTEG, 32'(integ), 34'h0);
      apb(1'b1, `ATS_OFF_SSDLY, 32'(ssd), 34'h0);
      apb(1'b1, `ATS_OFF_SSW, 32'(ssw), 34'h0);
      apb(1'b1, `ATS_OFF_CSPER, 32'(per), 34'h0);
      // Event clock itself already shows as busy
      q_busy.push_back((b1 + acq + integ + FB) * TC + 1);
      q_int.push_back(integ * TC);
      q_gap.push_back((b1 + acq) * TC);
      if (ssw > 0) q_ofs.push_back(ssd * TC);
      if (ssw > 0) q_ss.push_back((se - ssd) * TC);
      n = (per > 0 && per < integ) ? integ / per : 0;
      q_cnt.push_back(n);
      repeat (n) q_ph.push_back(per * TC / 2);
   endtask

   task automatic kick;
      hold <= 3'(1 + $urandom % 4);
      fire <= 1'b1;
      @(posedge core_clk);
      fire <= 1'b0;
   endtask

   task automatic run(input bit swt, input logic [31:0] st);
      if (swt) begin
         apb(1'b1, `ATS_OFF_CTRL, 32'h10, 34'h0);
      end else begin
         kick();
         while (ext_trig !== 1'b1) @(posedge core_clk);
         n = 0;
         while (acq_busy !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            n++;
         end
         check("evt_lat", 32'h2, 32'(n));
      end
      repeat (50) @(posedge core_clk);
      kick();
      apb(1'b0, `ATS_OFF_STATUS, 32'h0, {2'b10, st});
      while (acq_busy !== 1'b0) @(posedge core_clk);
   endtask

   always @(posedge core_clk) begin
      if (rst) begin
         bw = 0;
         iw = 0;
         sw = 0;
         pw = 0;
         np = 0;
      end else begin
         if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && q_apb.size() > 0) begin
            ea = q_apb.pop_front();
            check("pslverr", 32'(ea[32]), 32'(pslverr));
            if (ea[33]) check("prdata", ea[31:0], prdata);
         end
         if (acq_busy === 1'b1) bw++;
         if (integrating === 1'b1 && iw == 0) pop("int_gap", q_gap, bw - 1, 1'b1);
         if (integrating === 1'b1) iw++;
         else if (iw > 0) pop("int_len", q_int, iw, 1'b0);
         if (integrating !== 1'b1) iw = 0;
         if (single_strobe === 1'b1 && sw == 0) pop("ss_ofs", q_ofs, bw - 1, 1'b1);
         if (single_strobe === 1'b1) sw++;
         else if (sw > 0) pop("ss_len", q_ss, sw, 1'b0);
         if (single_strobe !== 1'b1) sw = 0;
         if (pulse_train === 1'b1) pw++;
         else if (pw > 0) np++;
         if (pulse_train !== 1'b1 && pw > 0) pop("train_hi", q_ph, pw, 1'b0);
         if (pulse_train !== 1'b1) pw = 0;
         if (acq_busy !== 1'b1 && bw > 0) pop("busy_len", q_busy, bw, 1'b0);
         if (acq_busy !== 1'b1 && bw > 0) pop("train_cnt", q_cnt, np, 1'b0);
         if (acq_busy !== 1'b1) np = 0;
         if (acq_busy !== 1'b1) bw = 0;
      end
      tcnt++;
      if (tcnt == 60000) begin
         miscompares++;
         close_out();
      end
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fire = 1'b0;
      hold = 3'h1;
      void'($urandom(61441));
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, `ATS_OFF_CTRL, 32'h0, {2'b10, `ATS_ZERO_RST});
      apb(1'b0, `ATS_OFF_INTEG, 32'h0, {2'b10, `ATS_INTEG_RST});
      apb(1'b0, 8'h1C, 32'h0, {2'b11, 32'h0});
      apb(1'b1, 8'h1C, 32'h5, {2'b01, 32'h0});
      kick();
      repeat (40) @(posedge core_clk);
      check("sw_mode_ext", 32'h0, 32'(acq_busy));
      integ = 10;
      acq = 3;
      ssd = 2;
      ssw = 300;
      per = 4;
      prog();
      run(1'b1, 32'h1);
      apb(1'b1, `ATS_OFF_CTRL, 32'(`ATS_MODE_EDGE), 34'h0);
      // Edge arriving and leaving while frozen must not start a cycle
      ce <= 1'b0;
      kick();
      repeat (10) @(posedge core_clk);
      ce <= 1'b1;
      repeat (4) @(posedge core_clk);
      check("ce_freeze", 32'h0, 32'(acq_busy));
      for (int k = 0; k < 4; k++) begin
         acq = $urandom % 8;
         per = 2 + $urandom % 9;
         ssd = 1 + $urandom % 4;
         ssw = 1 + $urandom % 300;
         prog();
         run(1'b0, 32'h1);
      end
      apb(1'b1, `ATS_OFF_CTRL, 32'(`ATS_MODE_LEVEL), 34'h0);
      apb(1'b0, `ATS_OFF_CTRL, 32'h0, {2'b10, 32'(`ATS_MODE_LEVEL)});
      integ = 220;
      acq = 0;
      ssw = 0;
      per = 7;
      prog();
      run(1'b0, 32'h3);
      close_out();
   end
endmodule
